// ==== rtl/egress_tag_pkg.sv ====
// Shared constants, field layouts and carriers of the egress tag lookup.
// Assumes one core clock; every user writes egress_tag_pkg::name.
package egress_tag_pkg;
  localparam int ENTRY_COUNT = 256;
  localparam int PORT_COUNT = 12;
  localparam int IDX_W = 8;
  localparam int ADDR_W = 9;
  localparam int KEY_W = 28;
  localparam int ACT_W = 74;
  localparam int MAC_W = 48;
  localparam int MAC_MC_BIT = 40;
  localparam int CNT_W = 32;
  localparam logic [MAC_W-1:0] MAC_BROADCAST = 48'hFFFFFFFFFFFF;
  localparam logic [15:0] TPID_CTAG = 16'h8100;
  localparam logic [15:0] TPID_STAG = 16'h88A8;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_KEY = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_VALID = 8'h0C;
  localparam logic [7:0] REG_ACT0 = 8'h10;
  localparam logic [7:0] REG_ACT1 = 8'h14;
  localparam logic [7:0] REG_ACT2 = 8'h18;
  localparam logic [7:0] REG_COUNT = 8'h1C;
  localparam int CMD_DEFAULT_BIT = 8;
  localparam int CMD_WRITE_BIT = 9;
  localparam int ACT_HIT_BIT = 73;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  typedef enum logic [1:0] {OUTER_PORT_ALLOWED = 2'b00, OUTER_PUSH_A = 2'b01,
                            OUTER_FORCE_PORT = 2'b10, OUTER_UNTAGGED = 2'b11} outer_e;
  typedef enum logic [1:0] {TPID_SEL_CTAG = 2'b00, TPID_SEL_STAG = 2'b01,
                            TPID_SEL_CUSTOM = 2'b10, TPID_SEL_BY_KIND = 2'b11} tpid_sel_e;
  typedef enum logic [1:0] {PRI_SEL_CLASS = 2'b00, PRI_SEL_VALUE = 2'b01,
                            PRI_SEL_MAPPED = 2'b10, PRI_SEL_QOS = 2'b11} pri_sel_e;
  typedef enum logic [1:0] {DEI_SEL_CLASS = 2'b00, DEI_SEL_VALUE = 2'b01,
                            DEI_SEL_MAPPED = 2'b10, DEI_SEL_DROP = 2'b11} dei_sel_e;

  typedef struct packed {
    logic [2:0] pcp; logic dp; logic [11:0] vid; logic dest_broadcast_flag;
    logic dest_multicast_flag; logic [1:0] rsvd; logic [3:0] receive_port_key; logic [3:0] transmit_port_key;
  } lookup_key_s;

  typedef struct packed {
    logic hit; logic [23:0] rsvd;
    logic second_tag_eligible_value; logic [2:0] second_tag_priority_value; logic [11:0] second_tag_vlan_value;
    logic first_tag_eligible_value; logic [2:0] first_tag_priority_value; logic [11:0] first_tag_vlan_value;
    dei_sel_e second_tag_eligible_select; pri_sel_e second_tag_priority_select;
    logic second_tag_vlan_select; tpid_sel_e second_tag_tpid_select;
    dei_sel_e first_tag_eligible_select; pri_sel_e first_tag_priority_select;
    logic first_tag_vlan_select; tpid_sel_e first_tag_tpid_select;
    logic push_inner; outer_e push_outer;
  } action_s;

  typedef struct packed {
    logic [3:0] tx_port; logic [3:0] rx_port; logic [MAC_W-1:0] dmac;
    logic [11:0] vid; logic drop_precedence_level; logic [2:0] pcp; logic dei; logic [2:0] qos;
    logic internal_header_tag_kind; logic [2:0] map_pcp; logic map_dei;
    logic [15:0] port_custom_tpid; logic port_tag_ena;
  } frame_req_s;

  typedef struct packed {
    logic [15:0] tpid; logic [11:0] vid; logic [2:0] pcp; logic dei;
  } tag_s;

  typedef struct packed {
    logic push_port_tag; logic push_a; logic push_b; tag_s tag_a; tag_s tag_b;
    logic hit; logic [IDX_W-1:0] entry;
  } tag_result_s;
endpackage : egress_tag_pkg

// ==== rtl/action_ram.sv ====
// Action store: one write port and two read ports with registered read data.
// A read of a word in the cycle that it is written returns the old contents; the caller reads port 1 at the write address.
`timescale 1ns/1ns
module action_ram #(
  parameter int WIDTH = egress_tag_pkg::ACT_W,
  parameter int DEPTH = egress_tag_pkg::ENTRY_COUNT + egress_tag_pkg::PORT_COUNT,
  parameter int AW = egress_tag_pkg::ADDR_W
) (
  input wire logic clk_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic [AW-1:0] rd0_addr_in,
  output logic [WIDTH-1:0] rd0_data_out,
  input wire logic [AW-1:0] rd1_addr_in,
  output logic [WIDTH-1:0] rd1_data_out
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    rd0_data_out <= mem[rd0_addr_in];
    rd1_data_out <= mem[rd1_addr_in];
  end
endmodule : action_ram

// ==== rtl/tag_select.sv ====
// Turns one action vector and the frame's classification into the tags to push.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module tag_select (
  input wire egress_tag_pkg::action_s act_in,
  input wire egress_tag_pkg::frame_req_s req_in,
  output egress_tag_pkg::tag_result_s res_out
);
  function automatic egress_tag_pkg::tag_s pick(input egress_tag_pkg::tpid_sel_e tsel, input logic vsel,
      input egress_tag_pkg::pri_sel_e psel, input egress_tag_pkg::dei_sel_e dsel, input logic [11:0] vval,
      input logic [2:0] pval, input logic dval, input egress_tag_pkg::frame_req_s r);
    egress_tag_pkg::tag_s t;
    t = '0;
    case (tsel)
      egress_tag_pkg::TPID_SEL_CTAG: t.tpid = egress_tag_pkg::TPID_CTAG;
      egress_tag_pkg::TPID_SEL_STAG: t.tpid = egress_tag_pkg::TPID_STAG;
      egress_tag_pkg::TPID_SEL_CUSTOM: t.tpid = r.port_custom_tpid;
      default: t.tpid = r.internal_header_tag_kind ? r.port_custom_tpid : egress_tag_pkg::TPID_CTAG;
    endcase
    // The sum wraps at twelve bits, like any VID arithmetic on the wire.
    t.vid = vsel ? vval : 12'(r.vid + vval);
    case (psel)
      egress_tag_pkg::PRI_SEL_CLASS: t.pcp = r.pcp;
      egress_tag_pkg::PRI_SEL_VALUE: t.pcp = pval;
      egress_tag_pkg::PRI_SEL_MAPPED: t.pcp = r.map_pcp;
      default: t.pcp = r.qos;
    endcase
    case (dsel)
      egress_tag_pkg::DEI_SEL_CLASS: t.dei = r.dei;
      egress_tag_pkg::DEI_SEL_VALUE: t.dei = dval;
      egress_tag_pkg::DEI_SEL_MAPPED: t.dei = r.map_dei;
      default: t.dei = r.drop_precedence_level;
    endcase
    return t;
  endfunction : pick

  always_comb begin
    res_out = '0;
    res_out.push_a = (act_in.push_outer == egress_tag_pkg::OUTER_PUSH_A);
    res_out.push_port_tag = (act_in.push_outer == egress_tag_pkg::OUTER_FORCE_PORT) ||
        ((act_in.push_outer == egress_tag_pkg::OUTER_PORT_ALLOWED) && req_in.port_tag_ena);
    res_out.push_b = act_in.push_inner;
    res_out.tag_a = pick(act_in.first_tag_tpid_select, act_in.first_tag_vlan_select,
        act_in.first_tag_priority_select, act_in.first_tag_eligible_select, act_in.first_tag_vlan_value,
        act_in.first_tag_priority_value, act_in.first_tag_eligible_value, req_in);
    res_out.tag_b = pick(act_in.second_tag_tpid_select, act_in.second_tag_vlan_select,
        act_in.second_tag_priority_select, act_in.second_tag_eligible_select, act_in.second_tag_vlan_value,
        act_in.second_tag_priority_value, act_in.second_tag_eligible_value, req_in);
  end
endmodule : tag_select

// ==== rtl/egress_tag_lookup.sv ====
// Egress tag lookup: key build, 256-entry masked match, per-port default action,
// tag resolution, and an AXI4-Lite slave that programs entries through a cache.
// Assumes one request per destination port and cycle; the pipeline never stalls.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
module egress_tag_lookup #(
  parameter int ENTRIES = egress_tag_pkg::ENTRY_COUNT,
  parameter int PORTS = egress_tag_pkg::PORT_COUNT
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [7:0] axi_awaddr_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  output logic [1:0] axi_bresp_out,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  input wire logic [7:0] axi_araddr_in,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  input wire logic req_valid_in,
  input wire egress_tag_pkg::frame_req_s req_in,
  output logic res_valid_out,
  output egress_tag_pkg::tag_result_s res_out
);
  localparam int IW = egress_tag_pkg::IDX_W;
  localparam int AW = egress_tag_pkg::ADDR_W;
  localparam int KW = egress_tag_pkg::KEY_W;
  localparam int XW = egress_tag_pkg::ACT_W;

  // Match side: key, care mask and valid flag per entry, all in flops.
  logic [KW-1:0] key_r [ENTRIES];
  logic [KW-1:0] mask_r [ENTRIES];
  logic [ENTRIES-1:0] valid_r;
  logic [ENTRIES-1:0] hit_r;
  logic [ENTRIES-1:0] match;

  // Software cache and command decode.
  logic [KW-1:0] cache_key_r;
  logic [KW-1:0] cache_mask_r;
  logic cache_valid_r;
  logic [XW-1:0] cache_act_r;
  logic [egress_tag_pkg::CNT_W-1:0] count_r;
  logic rd_pend_r;
  logic [IW-1:0] rd_idx_r;
  logic rd_def_r;

  logic wr_take;
  logic rd_take;
  logic cmd_go;
  logic cmd_write;
  logic cmd_def;
  logic [IW-1:0] cmd_idx;
  logic cmd_ok;
  logic [AW-1:0] cmd_addr;
  logic [XW-1:0] sw_rd_data;

  // Lookup pipeline.
  egress_tag_pkg::lookup_key_s key_now;
  logic any_now;
  logic [IW-1:0] idx_now;
  logic s1_valid_r;
  logic s1_hit_r;
  logic [IW-1:0] s1_idx_r;
  logic [AW-1:0] s1_addr_r;
  egress_tag_pkg::lookup_key_s s1_key_r;
  egress_tag_pkg::frame_req_s s1_req_r;
  logic s2_valid_r;
  logic s2_hit_r;
  logic [IW-1:0] s2_idx_r;
  egress_tag_pkg::frame_req_s s2_req_r;
  logic [XW-1:0] s2_act_raw;
  egress_tag_pkg::action_s s2_act;
  egress_tag_pkg::tag_result_s res_nxt;

  always_comb begin
    key_now = '0;
    key_now.transmit_port_key = req_in.tx_port;
    key_now.receive_port_key = req_in.rx_port;
    key_now.dest_multicast_flag = req_in.dmac[egress_tag_pkg::MAC_MC_BIT];
    key_now.dest_broadcast_flag = (req_in.dmac == egress_tag_pkg::MAC_BROADCAST);
    key_now.vid = req_in.vid;
    key_now.dp = req_in.drop_precedence_level;
    key_now.pcp = req_in.pcp;
  end

  // Reserved key bits are forced to zero in key_now, and the care mask written by software
  // excludes them, so a stray value on those bits never blocks a match.
  for (genvar g = 0; g < ENTRIES; g++) begin : g_cmp
    assign match[g] = valid_r[g] && (((key_now ^ key_r[g]) & mask_r[g]) == '0);
  end

  // Lowest index wins when several entries match.
  always_comb begin
    any_now = 1'b0;
    idx_now = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (match[i]) begin
        any_now = 1'b1;
        idx_now = IW'(i);
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_valid_r <= 1'b0;
      s1_hit_r <= 1'b0;
      s1_idx_r <= '0;
      s1_addr_r <= '0;
      s1_key_r <= '0;
      s1_req_r <= '0;
    end else begin
      s1_valid_r <= req_valid_in;
      s1_hit_r <= any_now;
      s1_idx_r <= idx_now;
      s1_key_r <= key_now;
      s1_req_r <= req_in;
      // A miss reads the default action kept after the entries.
      s1_addr_r <= any_now ? AW'(idx_now) : AW'(ENTRIES + int'(req_in.tx_port));
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s2_valid_r <= 1'b0;
      s2_hit_r <= 1'b0;
      s2_idx_r <= '0;
      s2_req_r <= '0;
    end else begin
      s2_valid_r <= s1_valid_r;
      s2_hit_r <= s1_hit_r;
      s2_idx_r <= s1_idx_r;
      s2_req_r <= s1_req_r;
    end
  end

  action_ram #(.WIDTH(XW), .DEPTH(ENTRIES + PORTS), .AW(AW)) u_ram (
    .clk_in(clk_in),
    .wr_en_in(cmd_go && cmd_write && cmd_ok),
    .wr_addr_in(cmd_addr),
    .wr_data_in({1'b0, cache_act_r[egress_tag_pkg::ACT_HIT_BIT-1:0]}),
    .rd0_addr_in(s1_addr_r),
    .rd0_data_out(s2_act_raw),
    .rd1_addr_in(cmd_addr),
    .rd1_data_out(sw_rd_data)
  );

  // Matched and default actions take the very same path.
  assign s2_act = egress_tag_pkg::action_s'(s2_act_raw);

  tag_select u_sel (
    .act_in(s2_act),
    .req_in(s2_req_r),
    .res_out(res_nxt)
  );

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      res_valid_out <= 1'b0;
      res_out <= '0;
    end else begin
      res_valid_out <= s2_valid_r;
      res_out <= res_nxt;
      res_out.hit <= s2_hit_r;
      res_out.entry <= s2_idx_r;
    end
  end

  // Hit bits: a lookup hit sets, an action rewrite clears, and the set wins.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hit_r <= '0;
    end else begin
      for (int i = 0; i < ENTRIES; i++) begin
        if (req_valid_in && any_now && (idx_now == IW'(i))) begin
          hit_r[i] <= 1'b1;
        end else if (cmd_go && cmd_write && !cmd_def && (cmd_idx == IW'(i))) begin
          hit_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_r <= '0;
    end else if (req_valid_in) begin
      count_r <= count_r + 1'b1;
    end
  end

  // AXI4-Lite write side: address and data are taken together, one at a time.
  assign wr_take = axi_awready_out && axi_awvalid_in && axi_wvalid_in;
  assign rd_take = axi_arready_out && axi_arvalid_in;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      axi_awready_out <= 1'b0;
      axi_wready_out <= 1'b0;
      axi_bvalid_out <= 1'b0;
      axi_bresp_out <= egress_tag_pkg::RESP_OKAY;
    end else begin
      axi_awready_out <= axi_awvalid_in && axi_wvalid_in && !axi_awready_out && !axi_bvalid_out;
      axi_wready_out <= axi_awvalid_in && axi_wvalid_in && !axi_awready_out && !axi_bvalid_out;
      if (wr_take) begin
        axi_bvalid_out <= 1'b1;
        axi_bresp_out <= (axi_awaddr_in <= egress_tag_pkg::REG_ACT2 && axi_awaddr_in[1:0] == 2'h0) ?
            egress_tag_pkg::RESP_OKAY : egress_tag_pkg::RESP_SLVERR;
      end else if (axi_bready_in) begin
        axi_bvalid_out <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  assign cmd_go = wr_take && (axi_awaddr_in == egress_tag_pkg::REG_CMD);
  assign cmd_idx = axi_wdata_in[IW-1:0];
  assign cmd_def = axi_wdata_in[egress_tag_pkg::CMD_DEFAULT_BIT];
  assign cmd_write = axi_wdata_in[egress_tag_pkg::CMD_WRITE_BIT];
  assign cmd_ok = !cmd_def || (int'(cmd_idx) < PORTS);
  assign cmd_addr = cmd_def ? AW'(ENTRIES + int'(cmd_idx)) : AW'(cmd_idx);

  // Cache registers, plus the read-back that fills them, or only the action for a default, one cycle after a command.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cache_key_r <= '0;
      cache_mask_r <= '0;
      cache_valid_r <= 1'b0;
      cache_act_r <= '0;
      rd_pend_r <= 1'b0;
      rd_idx_r <= '0;
      rd_def_r <= 1'b0;
    end else begin
      rd_pend_r <= cmd_go && !cmd_write && cmd_ok;
      rd_idx_r <= cmd_idx;
      rd_def_r <= cmd_def;
      if (rd_pend_r) begin
        cache_act_r <= {rd_def_r ? 1'b0 : hit_r[rd_idx_r], sw_rd_data[egress_tag_pkg::ACT_HIT_BIT-1:0]};
        if (!rd_def_r) begin
          cache_key_r <= key_r[rd_idx_r];
          cache_mask_r <= mask_r[rd_idx_r];
          cache_valid_r <= valid_r[rd_idx_r];
        end
      end else if (wr_take) begin
        case (axi_awaddr_in)
          egress_tag_pkg::REG_KEY: cache_key_r <= KW'(merge(32'(cache_key_r), axi_wdata_in, axi_wstrb_in));
          egress_tag_pkg::REG_MASK: cache_mask_r <= KW'(merge(32'(cache_mask_r), axi_wdata_in, axi_wstrb_in));
          egress_tag_pkg::REG_VALID: cache_valid_r <= axi_wstrb_in[0] ? axi_wdata_in[0] : cache_valid_r;
          egress_tag_pkg::REG_ACT0: cache_act_r[31:0] <= merge(cache_act_r[31:0], axi_wdata_in, axi_wstrb_in);
          egress_tag_pkg::REG_ACT1: cache_act_r[63:32] <= merge(cache_act_r[63:32], axi_wdata_in, axi_wstrb_in);
          egress_tag_pkg::REG_ACT2: cache_act_r[XW-1:64] <=
              (XW-64)'(merge(32'(cache_act_r[XW-1:64]), axi_wdata_in, axi_wstrb_in));
          default: cache_valid_r <= cache_valid_r;
        endcase
      end
    end
  end

  // Reserved action bits are stored as written; software keeps them zero.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      valid_r <= '0;
      for (int i = 0; i < ENTRIES; i++) begin
        key_r[i] <= '0;
        mask_r[i] <= '0;
      end
    end else if (cmd_go && cmd_write && !cmd_def) begin
      key_r[cmd_idx] <= cache_key_r;
      mask_r[cmd_idx] <= cache_mask_r;
      valid_r[cmd_idx] <= cache_valid_r;
    end
  end

  // AXI4-Lite read side.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      axi_arready_out <= 1'b0;
      axi_rvalid_out <= 1'b0;
      axi_rdata_out <= egress_tag_pkg::WORD_ZERO;
      axi_rresp_out <= egress_tag_pkg::RESP_OKAY;
    end else begin
      axi_arready_out <= axi_arvalid_in && !axi_arready_out && !axi_rvalid_out;
      if (rd_take) begin
        axi_rvalid_out <= 1'b1;
        axi_rresp_out <= egress_tag_pkg::RESP_OKAY;
        case (axi_araddr_in)
          egress_tag_pkg::REG_CMD: axi_rdata_out <= egress_tag_pkg::WORD_ZERO;
          egress_tag_pkg::REG_KEY: axi_rdata_out <= 32'(cache_key_r);
          egress_tag_pkg::REG_MASK: axi_rdata_out <= 32'(cache_mask_r);
          egress_tag_pkg::REG_VALID: axi_rdata_out <= 32'(cache_valid_r);
          egress_tag_pkg::REG_ACT0: axi_rdata_out <= cache_act_r[31:0];
          egress_tag_pkg::REG_ACT1: axi_rdata_out <= cache_act_r[63:32];
          egress_tag_pkg::REG_ACT2: axi_rdata_out <= 32'(cache_act_r[XW-1:64]);
          egress_tag_pkg::REG_COUNT: axi_rdata_out <= count_r;
          default: begin
            axi_rdata_out <= egress_tag_pkg::WORD_ZERO;
            axi_rresp_out <= egress_tag_pkg::RESP_SLVERR;
          end
        endcase
      end else if (axi_rready_in) begin
        axi_rvalid_out <= 1'b0;
      end
    end
  end

  chk_one_result: assert property (@(posedge clk_in) disable iff (rst_in)
      req_valid_in |-> ##3 res_valid_out) else $error("request without a result three cycles later");
  chk_no_extra_result: assert property (@(posedge clk_in) disable iff (rst_in)
      res_valid_out |-> $past(req_valid_in, 3)) else $error("result without a request");
  chk_port_fields: assert property (@(posedge clk_in) disable iff (rst_in)
      s1_valid_r |-> s1_key_r[7:0] == {$past(req_in.rx_port), $past(req_in.tx_port)})
      else $error("port fields misplaced in key");
  chk_mc_flag: assert property (@(posedge clk_in) disable iff (rst_in)
      s1_valid_r |-> s1_key_r.dest_multicast_flag == s1_req_r.dmac[egress_tag_pkg::MAC_MC_BIT])
      else $error("multicast flag wrong");
  chk_bc_flag: assert property (@(posedge clk_in) disable iff (rst_in)
      s1_valid_r && (s1_req_r.dmac == egress_tag_pkg::MAC_BROADCAST) |-> s1_key_r.dest_broadcast_flag)
      else $error("broadcast flag not set");
  chk_class_fields: assert property (@(posedge clk_in) disable iff (rst_in)
      s1_valid_r |-> s1_key_r[KW-1:12] == {s1_req_r.pcp, s1_req_r.drop_precedence_level, s1_req_r.vid})
      else $error("classification fields misplaced in key");
  chk_default_addr: assert property (@(posedge clk_in) disable iff (rst_in)
      s1_valid_r && !s1_hit_r |-> s1_addr_r == AW'(ENTRIES + int'(s1_req_r.tx_port)))
      else $error("miss did not select the port default");
  chk_hit_sets: assert property (@(posedge clk_in) disable iff (rst_in)
      s1_valid_r && s1_hit_r |-> hit_r[s1_idx_r]) else $error("hit bit not set on match");
  chk_untag_code: assert property (@(posedge clk_in) disable iff (rst_in)
      s2_valid_r && s2_act.push_outer == egress_tag_pkg::OUTER_UNTAGGED |=> !res_out.push_a && !res_out.push_port_tag)
      else $error("untag code still pushed a tag");
  chk_inner_tag: assert property (@(posedge clk_in) disable iff (rst_in)
      s2_valid_r |=> res_out.push_b == $past(s2_act.push_inner)) else $error("inner tag push wrong");
  chk_hit_holds: assert property (@(posedge clk_in) disable iff (rst_in)
      hit_r[ENTRIES-1] && !(cmd_go && cmd_write && !cmd_def && cmd_idx == IW'(ENTRIES - 1)) |=> hit_r[ENTRIES-1])
      else $error("hit bit dropped without a rewrite");
endmodule : egress_tag_lookup

// ==== tb/classifier_model.sv ====
// Classifier side of the lookup port: offers one request per frame and destination port.
// Assumes send is called just after a rising clock edge.
`timescale 1ns/1ns
module classifier_model (
  input wire logic clk_in,
  output logic req_valid_out,
  output egress_tag_pkg::frame_req_s req_out
);
  initial {req_valid_out, req_out} = 99'h0;
  task send(input egress_tag_pkg::frame_req_s r);
    req_valid_out <= 1'b1;
    req_out <= r;
    @(posedge clk_in);
    req_valid_out <= 1'b0;
    // Released fields are inverted so that a late sample cannot pass.
    req_out <= ~r;
  endtask : send
endmodule : classifier_model

// ==== tb/egress_tag_lookup_test.sv ====
// Bench of the egress tag lookup: defaults and entries go in over AXI4-Lite, random frames are checked.
// Assumes the classifier model drives the lookup port.
`timescale 1ns/1ns
module egress_tag_lookup_test;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wrd, bv, arr, rv, reqv, resv;
  logic [7:0] awa = 8'h00, ara = 8'h00, n;
  logic [31:0] wd = 32'h00000000, rdw, d;
  logic [1:0] br, rr, c;
  egress_tag_pkg::frame_req_s req, f, g;
  egress_tag_pkg::tag_result_s res;
  egress_tag_pkg::action_s a, dft [12];
  int err_total = 0, comparisons = 0, cyc = 0, sent = 0;
  egress_tag_lookup dut_u (.clk_in(clk), .rst_in(rst), .axi_awvalid_in(awv), .axi_awready_out(awr),
    .axi_awaddr_in(awa), .axi_wvalid_in(wv), .axi_wready_out(wrd), .axi_wdata_in(wd), .axi_wstrb_in(4'hF),
    .axi_bvalid_out(bv), .axi_bready_in(bry), .axi_bresp_out(br), .axi_arvalid_in(arv), .axi_arready_out(arr),
    .axi_araddr_in(ara), .axi_rvalid_out(rv), .axi_rready_in(rry), .axi_rdata_out(rdw), .axi_rresp_out(rr),
    .req_valid_in(reqv), .req_in(req), .res_valid_out(resv), .res_out(res));
  classifier_model part_u (.clk_in(clk), .req_valid_out(reqv), .req_out(req));
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    if (++cyc == 20000) err_total++;
    if (cyc == 20000) end_of_test();
  end
  task end_of_test;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task chk(input string s, input logic [73:0] e, input logic [73:0] v);
    comparisons++;
    if (v !== e) $display("ERROR %s expected %h seen %h", s, e, v);
    if (v !== e) err_total++;
  endtask : chk
  task axi(input logic w, input logic [7:0] ad, input logic [31:0] dw, input logic [1:0] e);
    int k;
    k = 0;
    @(posedge clk);
    {awv, wv, bry, arv, rry} <= {w, w, w, !w, !w};
    {awa, ara, wd} <= {ad, ad, dw};
    do @(posedge clk); while ((w ? awr : arr) !== 1'b1 && ++k < 99);
    if (w) chk("wready", 1'b1, wrd);
    {awv, wv, arv} <= 3'b000;
    do @(posedge clk); while ((w ? bv : rv) !== 1'b1 && ++k < 99);
    {bry, rry} <= 2'b00;
    if (k >= 99) chk("axi_wait", 1'b0, 1'b1);
    d = rdw;
    chk("resp", e, w ? br : rr);
  endtask : axi
  task prog(input logic [7:0] ix, input logic df, input logic [27:0] k, input logic [27:0] m, input logic [73:0] x);
    logic [31:0] w [6];
    w = '{{4'h0, k}, {4'h0, m}, 32'h00000001, x[31:0], x[63:32], {22'h0, x[73:64]}};
    for (int i = 0; i < 6; i++) axi(1'b1, egress_tag_pkg::REG_KEY + 8'(4 * i), w[i], 2'h0);
    axi(1'b1, egress_tag_pkg::REG_CMD, {22'h0, 1'b1, df, ix}, 2'h0);
  endtask : prog
  task hitchk(input logic [7:0] ix, input logic e);
    axi(1'b1, egress_tag_pkg::REG_CMD, {24'h000000, ix}, 2'h0);
    axi(1'b0, egress_tag_pkg::REG_ACT2, 32'h00000000, 2'h0);
    chk("hit", e, d[9]);
  endtask : hitchk
  function automatic logic [27:0] key(input egress_tag_pkg::frame_req_s r);
    return {r.pcp, r.drop_precedence_level, r.vid, r.dmac == 48'hFFFFFFFFFFFF, r.dmac[40], 2'h0, r.rx_port, r.tx_port};
  endfunction : key
  function automatic egress_tag_pkg::tag_s ex_tag(input logic [6:0] s, input logic [15:0] v,
      input egress_tag_pkg::frame_req_s r);
    ex_tag.tpid = s[1:0] == 0 ? 16'h8100 : s[1:0] == 1 ? 16'h88A8 : s[0] && !r.internal_header_tag_kind ? 16'h8100
      : r.port_custom_tpid;
    ex_tag.vid = s[2] ? v[11:0] : r.vid + v[11:0];
    ex_tag.pcp = s[4] ? (s[3] ? r.qos : r.map_pcp) : (s[3] ? v[14:12] : r.pcp);
    ex_tag.dei = s[6] ? (s[5] ? r.drop_precedence_level : r.map_dei) : (s[5] ? v[15] : r.dei);
  endfunction : ex_tag
  task look(input egress_tag_pkg::frame_req_s r, input egress_tag_pkg::action_s x, input logic h, input logic [7:0] ix);
    @(posedge clk);
    part_u.send(r);
    sent++;
    repeat (2) @(posedge clk);
    #1 chk("res_valid", 1'b1, resv);
    chk("push", {x.push_outer == 2 || x.push_outer == 0 && r.port_tag_ena, x.push_outer == 1, x.push_inner, h},
      {res.push_port_tag, res.push_a, res.push_b, res.hit});
    if (x.push_outer == 1) chk("tag_a", ex_tag(x[9:3], x[32:17], r), res.tag_a);
    if (x.push_inner) chk("tag_b", ex_tag(x[16:10], x[48:33], r), res.tag_b);
    if (h) chk("entry", ix, res.entry);
  endtask : look
  initial begin
    void'($urandom(32'h5BDF));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 36; i++) begin
      a = 74'({$urandom, $urandom, $urandom});
      c = i[1:0];
      // Passes 12 to 19 (entries 255 down to 178) give every selector every code, with the tags pushed where the code allows.
      if (i >= 12 && i < 20) a[16:0] = {c, c, c[0], c, c, c, c[0], c, 1'b1, i < 16 ? 2'b01 : c};
      a.rsvd = 24'h000000;
      a.hit = 1'b0;
      if (i < 12) dft[i] = a;
      if (i < 12) prog(8'(i), 1'b1, 28'h0000000, 28'h0000000, a);
      if (i < 12) continue;
      f = 98'({$urandom, $urandom, $urandom, $urandom});
      f.tx_port = 4'($urandom % 12);
      f.rx_port = 4'($urandom % 12);
      if (i % 4 == 1) f.dmac = 48'hFFFFFFFFFFFF;
      n = 8'(255 - (i - 12) * 11);
      prog(n, 1'b0, key(f) | 28'h0000300, 28'hFFFFCFF, a);
      repeat (2) look(f, a, 1'b1, n);
      hitchk(n, 1'b1);
      g = f;
      case (i % 7)
        0: g.tx_port = 4'((f.tx_port + 1) % 12);
        1: g.rx_port = 4'((f.rx_port + 1) % 12);
        2: g.dmac[40] = !f.dmac[40];
        3: g.dmac = f.dmac == 48'hFFFFFFFFFFFF ? ~48'h000000000001 : 48'hFFFFFFFFFFFF;
        4: g.vid = f.vid ^ 12'h001;
        5: g.drop_precedence_level = !f.drop_precedence_level;
        default: g.pcp = f.pcp ^ 3'h1;
      endcase
      look(g, dft[g.tx_port], 1'b0, 8'h00);
    end
    axi(1'b0, 8'h20, 32'h00000000, egress_tag_pkg::RESP_SLVERR);
    chk("unmapped_rdata", 32'h00000000, d);
    axi(1'b1, egress_tag_pkg::REG_COUNT, 32'h00000001, egress_tag_pkg::RESP_SLVERR);
    axi(1'b0, egress_tag_pkg::REG_COUNT, 32'h00000000, egress_tag_pkg::RESP_OKAY);
    chk("lookup_count", sent, d);
    end_of_test();
  end
endmodule : egress_tag_lookup_test
